// *** hw/dvm_pkg.sv ***
// Purpose: Shared constants for the playback volume and mixer registers
// Assumes: Register index is the printed offset, byte address is four times it
// Notes: 16-bit registers sit in the low bits of the 32-bit read data
package dvm_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // Register indices and byte addresses
  localparam logic [ADDR_W-1:0] PLAY_GAIN_IDX = 8'h02;
  localparam logic [ADDR_W-1:0] MIXER_GAIN_IDX = 8'h03;
  localparam logic [ADDR_W-1:0] PLAY_GAIN_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] MIXER_GAIN_ADDR = 8'h0c;
  // Playback gain fields
  localparam int unsigned LEFT_MUTE_BIT = 15;
  localparam int unsigned LEFT_VOL_LSB = 8;
  localparam int unsigned RIGHT_MUTE_BIT = 7;
  localparam int unsigned RIGHT_VOL_LSB = 0;
  // Mixer fields
  localparam int unsigned SIDE_MUTE_BIT = 15;
  localparam int unsigned SIDE_GAIN_LSB = 8;
  localparam int unsigned SRC_SEL_LSB = 5;
  localparam int unsigned SEL_TO_REC_BIT = 4;
  localparam int unsigned PHONE_TO_REC_BIT = 3;
  localparam int unsigned STEP_DONE_BIT = 0;
  // Reset values, sidetone gain limit and mixer write mask
  localparam logic [6:0] VOL_RESET = 7'h7f;
  localparam logic [6:0] SIDE_GAIN_RESET = 7'h45;
  localparam logic [6:0] SIDE_GAIN_MAX = 7'h5d;
  localparam logic [2:0] SRC_SEL_RESET = 3'h0;
  localparam logic [15:0] MIXER_WRITE_MASK = 16'hfff8;
  // Source selection codes
  typedef enum logic [2:0] {
    DVM_SRC_HEADSET = 3'b000,
    DVM_SRC_HANDSET = 3'b001,
    DVM_SRC_AUX_ONE = 3'b010,
    DVM_SRC_AUX_TWO = 3'b011,
    DVM_SRC_HEAD_AUXILIARY_INPUT_ONE = 3'b100,
    DVM_SRC_HEAD_AUXILIARY_INPUT_TWO = 3'b101,
    DVM_SRC_HAND_AUXILIARY_INPUT_ONE = 3'b110,
    DVM_SRC_HAND_AUXILIARY_INPUT_TWO = 3'b111
  } dvm_src_t;
endpackage

// *** hw/dvm_route.sv ***
// Purpose: Decodes source selection into per-input connect enables
// Assumes: Combinational, inputs from the register bank on the same clock
// Notes: Enable order is headset, handset, aux one, aux two
`timescale 1ns/100ps
module dvm_route
(
  // Selection
  input wire logic [2:0] sel_in,
  input wire logic enable_in,
  // Decoded enables
  output logic [3:0] connect_out,
  output logic differential_out
);
  // Nothing is connected while the selector is off
  always_comb
  begin
    connect_out = 4'h0;
    differential_out = sel_in[2];
    case (dvm_pkg::dvm_src_t'(sel_in))
      dvm_pkg::DVM_SRC_HEADSET: connect_out = 4'h1;
      dvm_pkg::DVM_SRC_HANDSET: connect_out = 4'h2;
      dvm_pkg::DVM_SRC_AUX_ONE: connect_out = 4'h4;
      dvm_pkg::DVM_SRC_AUX_TWO: connect_out = 4'h8;
      dvm_pkg::DVM_SRC_HEAD_AUXILIARY_INPUT_ONE: connect_out = 4'h5;
      dvm_pkg::DVM_SRC_HEAD_AUXILIARY_INPUT_TWO: connect_out = 4'h9;
      dvm_pkg::DVM_SRC_HAND_AUXILIARY_INPUT_ONE: connect_out = 4'h6;
      dvm_pkg::DVM_SRC_HAND_AUXILIARY_INPUT_TWO: connect_out = 4'ha;
      default: connect_out = 4'h0;
    endcase
    if (!enable_in)
    begin
      connect_out = 4'h0;
    end
  end
endmodule

// *** hw/dvm_regs.sv ***
// Purpose: Playback volume and mixer control register bank
// Assumes: Single 20 MHz clock, plain strobe register port
// Notes: Soft-stepping engine is outside; it reports the applied gain back
//
// Overview of operation
// - Left mute bit, resets muted
// - Left volume, half dB steps, resets max
// - Right mute bit, resets muted
// - Right volume, half dB steps, resets max
// - Sidetone mute bit, resets muted
// - Sidetone gain from -34.5 dB, half dB
// - Codes above top saturate at 12 dB on sidetone_target_out only
// - Sidetone gain resets to 0 dB code
// - Select codes 000 to 011 pick one single-ended source
// - Codes 100, 101 pair headset with aux
// - Codes 110, 111 pair handset with aux
// - Differential select invalidates sidetone path
// - Enable bit connects selected source to record
// - Bit connects phone input to record
// - Read-only flag: applied gain equals saturated setting
`timescale 1ns/100ps
module dvm_regs
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Feedback from the sidetone soft-stepping engine
  input wire logic [6:0] side_gain_applied_in,
  // Playback controls
  output logic left_play_mute_out,
  output logic [6:0] left_play_volume_out,
  output logic right_play_mute_out,
  output logic [6:0] right_play_volume_out,
  // Sidetone controls
  output logic sidetone_mute_out,
  output logic [6:0] sidetone_gain_out,
  output logic [6:0] sidetone_target_out,
  output logic sidetone_valid_out,
  // Record routing
  output logic [2:0] input_source_select_out,
  output logic [3:0] record_connect_out,
  output logic differential_out,
  output logic phone_input_to_record_out
);
  logic left_play_mute;
  logic [6:0] left_play_volume;
  logic right_play_mute;
  logic [6:0] right_play_volume;
  logic sidetone_mute;
  logic [6:0] sidetone_gain;
  logic [2:0] input_source_select;
  logic selected_input_to_record;
  logic phone_input_to_record;
  logic sidetone_step_done_flag;
  logic [31:0] rdata;
  logic [6:0] sidetone_target;
  logic [3:0] connect;
  logic diff_sel;
  logic next_left_play_mute;
  logic [6:0] next_left_play_volume;
  logic next_right_play_mute;
  logic [6:0] next_right_play_volume;
  logic next_sidetone_mute;
  logic [6:0] next_sidetone_gain;
  logic [2:0] next_input_source_select;
  logic next_selected_input_to_record;
  logic next_phone_input_to_record;
  logic next_sidetone_step_done_flag;
  logic [31:0] next_rdata;
  logic [3:0] next_connect;
  logic next_diff;
  logic next_valid;
  logic [6:0] next_target;
  logic [15:0] play_word;
  logic [15:0] mixer_word;
  logic wr_play;
  logic wr_mixer;

  // Full word decode, each register on its own aligned word
  assign wr_play = wr_in && (addr_in == dvm_pkg::PLAY_GAIN_ADDR);
  assign wr_mixer = wr_in && (addr_in == dvm_pkg::MIXER_GAIN_ADDR);

  // Saturate the gain code seen by the analog path; stored code is kept
  always_comb
  begin
    if (sidetone_gain > dvm_pkg::SIDE_GAIN_MAX)
    begin
      sidetone_target = dvm_pkg::SIDE_GAIN_MAX;
    end
    else
    begin
      sidetone_target = sidetone_gain;
    end
  end

  // Selector decode lives in its own module
  dvm_route u_route
  (
    .sel_in(input_source_select),
    .enable_in(selected_input_to_record),
    .connect_out(connect),
    .differential_out(diff_sel)
  );

  // Register words as seen on a read
  always_comb
  begin
    play_word = {left_play_mute, left_play_volume,
                 right_play_mute, right_play_volume};
    mixer_word = {sidetone_mute, sidetone_gain, input_source_select,
                  selected_input_to_record, phone_input_to_record,
                  2'b00, sidetone_step_done_flag};
  end

  // Next values of the writable fields
  always_comb
  begin
    next_left_play_mute = left_play_mute;
    next_left_play_volume = left_play_volume;
    next_right_play_mute = right_play_mute;
    next_right_play_volume = right_play_volume;
    next_sidetone_mute = sidetone_mute;
    next_sidetone_gain = sidetone_gain;
    next_input_source_select = input_source_select;
    next_selected_input_to_record = selected_input_to_record;
    next_phone_input_to_record = phone_input_to_record;
    if (wr_play)
    begin
      next_left_play_mute = wdata_in[dvm_pkg::LEFT_MUTE_BIT];
      next_left_play_volume =
        wdata_in[dvm_pkg::LEFT_VOL_LSB +: 7];
      next_right_play_mute = wdata_in[dvm_pkg::RIGHT_MUTE_BIT];
      next_right_play_volume =
        wdata_in[dvm_pkg::RIGHT_VOL_LSB +: 7];
    end
    // Bits 2..0 are never taken from the write data
    if (wr_mixer)
    begin
      next_sidetone_mute = wdata_in[dvm_pkg::SIDE_MUTE_BIT];
      next_sidetone_gain = wdata_in[dvm_pkg::SIDE_GAIN_LSB +: 7];
      next_input_source_select =
        wdata_in[dvm_pkg::SRC_SEL_LSB +: 3];
      next_selected_input_to_record =
        wdata_in[dvm_pkg::SEL_TO_REC_BIT];
      next_phone_input_to_record =
        wdata_in[dvm_pkg::PHONE_TO_REC_BIT];
    end
  end

  // Status, read data and registered outputs
  always_comb
  begin
    // Compare against the saturated target so codes above max settle
    next_sidetone_step_done_flag =
      (side_gain_applied_in == sidetone_target);
    next_rdata = 32'h0;
    if (rd_in)
    begin
      if (addr_in == dvm_pkg::PLAY_GAIN_ADDR)
      begin
        next_rdata = {16'h0, play_word};
      end
      else if (addr_in == dvm_pkg::MIXER_GAIN_ADDR)
      begin
        next_rdata = {16'h0, mixer_word & dvm_pkg::MIXER_WRITE_MASK |
                      {15'h0, sidetone_step_done_flag}};
      end
      else
      begin
        next_rdata = 32'h0; // Unmapped reads give zero
      end
    end
    next_connect = connect;
    next_diff = diff_sel;
    next_valid = !diff_sel;
    next_target = sidetone_target;
  end

  // Register update
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      left_play_mute <= 1'b1;
      left_play_volume <= dvm_pkg::VOL_RESET;
      right_play_mute <= 1'b1;
      right_play_volume <= dvm_pkg::VOL_RESET;
      sidetone_mute <= 1'b1;
      sidetone_gain <= dvm_pkg::SIDE_GAIN_RESET;
      input_source_select <= dvm_pkg::SRC_SEL_RESET;
      selected_input_to_record <= 1'b0;
      phone_input_to_record <= 1'b0;
      sidetone_step_done_flag <= 1'b0;
      rdata <= 32'h0;
      record_connect_out <= 4'h0;
      differential_out <= 1'b0;
      sidetone_valid_out <= 1'b0;
      sidetone_target_out <= dvm_pkg::SIDE_GAIN_RESET;
    end
    else
    begin
      left_play_mute <= next_left_play_mute;
      left_play_volume <= next_left_play_volume;
      right_play_mute <= next_right_play_mute;
      right_play_volume <= next_right_play_volume;
      sidetone_mute <= next_sidetone_mute;
      sidetone_gain <= next_sidetone_gain;
      input_source_select <= next_input_source_select;
      selected_input_to_record <= next_selected_input_to_record;
      phone_input_to_record <= next_phone_input_to_record;
      sidetone_step_done_flag <= next_sidetone_step_done_flag;
      rdata <= next_rdata;
      record_connect_out <= next_connect;
      differential_out <= next_diff;
      sidetone_valid_out <= next_valid;
      sidetone_target_out <= next_target;
    end
  end

  // Field outputs come straight from their flops
  assign left_play_mute_out = left_play_mute;
  assign left_play_volume_out = left_play_volume;
  assign right_play_mute_out = right_play_mute;
  assign right_play_volume_out = right_play_volume;
  assign sidetone_mute_out = sidetone_mute;
  assign sidetone_gain_out = sidetone_gain;
  assign input_source_select_out = input_source_select;
  assign phone_input_to_record_out = phone_input_to_record;
  assign rdata_out = rdata;
endmodule

// *** verification/dvm_regs_properties.sv ***
// Purpose: Port-level properties of the volume and mixer register bank
// Assumes: One clock domain, asynchronous active low reset
// Notes: Derived outputs lag the register fields by one cycle
`timescale 1ns/100ps
module dvm_regs_properties
(
  // Clock, reset and register port
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [6:0] side_gain_applied_in,
  // Control outputs
  input wire logic left_play_mute_out,
  input wire logic [6:0] left_play_volume_out,
  input wire logic right_play_mute_out,
  input wire logic [6:0] right_play_volume_out,
  input wire logic sidetone_mute_out,
  input wire logic [6:0] sidetone_gain_out,
  input wire logic [6:0] sidetone_target_out,
  input wire logic sidetone_valid_out,
  input wire logic [2:0] input_source_select_out,
  input wire logic [3:0] record_connect_out,
  input wire logic differential_out,
  input wire logic phone_input_to_record_out
);
  // Enables per select code, four bits each, code 0 lowest
  localparam logic [31:0] ROUTE = 32'ha6958421;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Register accesses
  sequence play_wr;
    wr_in && addr_in == 8'h08;
  endsequence
  sequence mix_wr;
    wr_in && addr_in == 8'h0c;
  endsequence
  sequence mix_rd;
    rd_in && addr_in == 8'h0c;
  endsequence
  chk_left_write: assert property (play_wr |=>
    {left_play_mute_out, left_play_volume_out} == $past(wdata_in[15:8]))
    else $error("left playback field not loaded");
  chk_right_write: assert property (play_wr |=>
    {right_play_mute_out, right_play_volume_out} == $past(wdata_in[7:0]))
    else $error("right playback field not loaded");
  chk_mixer_write: assert property (mix_wr |=>
    {sidetone_mute_out, sidetone_gain_out, input_source_select_out,
    phone_input_to_record_out} ==
    {$past(wdata_in[15:5]), $past(wdata_in[3])})
    else $error("mixer fields not loaded");
  chk_gain_saturate: assert property (sidetone_target_out ==
    ($past(sidetone_gain_out) > 7'h5d ? 7'h5d : $past(sidetone_gain_out)))
    else $error("sidetone target not saturated");
  chk_diff_valid: assert property ($past(reset_n_in) |->
    differential_out == $past(input_source_select_out[2]) &&
    sidetone_valid_out == !differential_out) else $error("valid wrong");
  chk_route_map: assert property (record_connect_out != 4'h0 |->
    record_connect_out == ROUTE[4*$past(input_source_select_out) +: 4])
    else $error("record routing wrong");
  chk_rdata_idle: assert property (rdata_out[31:16] == 16'h0 &&
    ($past(rd_in) || rdata_out == 32'h0)) else $error("rdata not idle");
  chk_reserved_zero: assert property (mix_rd |=>
    rdata_out[2:1] == 2'b00) else $error("reserved bits set");
  // Flag was registered against the saturated code on the same edge
  // that code reached the target port, so the target lags one less
  chk_flag_value: assert property (mix_rd |=> rdata_out[0] ==
    ($past(side_gain_applied_in, 2) == $past(sidetone_target_out)))
    else $error("step done flag wrong");
endmodule
bind dvm_regs dvm_regs_properties chk (.clk_in, .reset_n_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .side_gain_applied_in,
  .left_play_mute_out, .left_play_volume_out, .right_play_mute_out,
  .right_play_volume_out, .sidetone_mute_out, .sidetone_gain_out,
  .sidetone_target_out, .sidetone_valid_out, .input_source_select_out,
  .record_connect_out, .differential_out, .phone_input_to_record_out);

// *** verification/dvm_regs_bench.sv ***
// Purpose: Self-checking bench for the volume and mixer register bank
// Assumes: Read data stands one cycle after the read strobe
// Notes: Driver queues read expectations, a monitor compares them
`timescale 1ns/100ps
module dvm_regs_bench;
  localparam logic [31:0] ROUTE = 32'ha6958421;
  logic clk_in, reset_n_in, wr_in, rd_in, rd_d, differential_out;
  logic sidetone_valid_out;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out, d;
  logic [31:0] exp_q[$];
  logic [6:0] side_gain_applied_in, sidetone_target_out, sat;
  logic [3:0] record_connect_out;
  int mismatches, tests_run, cycles, seed;
  dvm_regs uut
  (
    .clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .side_gain_applied_in, .left_play_mute_out(), .left_play_volume_out(),
    .right_play_mute_out(), .right_play_volume_out(), .sidetone_mute_out(),
    .sidetone_gain_out(), .sidetone_target_out, .sidetone_valid_out,
    .input_source_select_out(), .record_connect_out, .differential_out,
    .phone_input_to_record_out()
  );
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // Strobes drop with one idle edge after, so no double drive
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    exp_q.push_back(v);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic do_reset();
    reset_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
  endtask
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Read data is only valid the cycle after the strobe
  always @(posedge clk_in)
  begin
    if (rd_d)
      check(rdata_out, exp_q.pop_front());
    rd_d <= rd_in;
  end
  // Hang guard, far above the 110 or so cycles needed
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  initial
  begin
    {reset_n_in, wr_in, rd_in, addr_in, wdata_in} = '0;
    side_gain_applied_in = 7'h45;
    seed = 32'h52e0;
    do_reset();
    rd(8'h08, 32'hffff);
    rd(8'h0c, 32'hc501);
    check(sidetone_valid_out, 1'b1);
    $display("Test reset done");
    repeat (8)
    begin
      d = $random(seed);
      wr(8'h08, d);
      rd(8'h08, {16'h0, d[15:0]});
    end
    $display("Test playback done");
    for (int s = 0; s < 8; s++)
    begin
      d = $random(seed);
      d[7:0] = {s[2:0], 1'b1, d[3], 3'b111};
      // Make sure at least one code lands in the saturating range
      if (s == 5)
      begin
        d[14:13] = 2'b11;
      end
      sat = (d[14:8] > 7'h5d) ? 7'h5d : d[14:8];
      side_gain_applied_in <= sat ^ {6'h0, s[0]};
      wr(8'h0c, d);
      repeat (2) @(posedge clk_in);
      check(record_connect_out, ROUTE[s*4 +: 4]);
      check(differential_out, s[2]);
      check(sidetone_target_out, sat);
      rd(8'h0c, {16'h0, d[15:3], 2'b00, !s[0]});
    end
    $display("Test mixer done");
    side_gain_applied_in <= 7'h00;
    wr(8'h0c, 32'h0088);
    wr(8'h10, 32'hffff);
    repeat (2) @(posedge clk_in);
    check(record_connect_out, 4'h0);
    check(sidetone_valid_out, 1'b0);
    rd(8'h10, 32'h0);
    rd(8'h0c, 32'h0089);
    do_reset();
    rd(8'h08, 32'hffff);
    $display("Test routing done");
    give_verdict();
  end
endmodule
